//--- include/dtsl_params.svh
// What this block does
// - Transmitter sends eleven equal slots per character, optionally ten.
// - Nine-bit circular shifter; stage starts zero, drive, wait, set one, rotate right.
// - From the tenth slot onward the serial output carries ones.
// - Activity flag blocks interrupts while any character is moving.
// - Receiver idles until a falling start edge, then loads the half-bit delay.
// - First sample one and a half bits after the edge, then every full bit.
// - Nine samples per character; the first eight form the received byte.
// - Samples enter the data register at the top and shift right.
// - Transmit and receive bit loops use identical cycle counts.
// - Bit period is 83 plus 14 times the reduced delay, in machine cycles.
// - Delay segment is 22 plus 14 per low unit plus 3595 per high unit.
// - One machine cycle equals two clock cycles.
// - Each low-byte delay step changes the bit period by 14 machine cycles, each high-byte step by 3595.
// - Bit period is counted in clocks, so rate follows the loaded delays and scales with the clock frequency.
// - Frame is zero start bit, eight data bits LSB first, stop bits at one.
// - A write changes the serial output only with its enable bit set.
// - Serial output is low straight after reset.
`ifndef DTSL_PARAMS_SVH
`define DTSL_PARAMS_SVH

// Frame shape
`define DTSL_SLOTS_LONG    11
`define DTSL_SLOTS_SHORT   10
`define DTSL_RX_SAMPLES    9

// Loop timing in machine cycles
`define DTSL_LOOP_OVH      61
`define DTSL_SEG_BASE      22
`define DTSL_STEP_LOW      14
`define DTSL_STEP_HIGH     3595
`define DTSL_CLK_PER_MC    2

// Reset levels
`define DTSL_SOD_RST       1'b0

`endif

//--- include/dtsl_pkg.sv
package dtsl_pkg;

	// Gray order from idle to the last slot; the return to idle flips both bits
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_SLOT = 2'b01,
		TX_LAST = 2'b11
	} dtsl_tx_state_type;

	// Gray order along the receive path
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_HALF = 2'b01,
		RX_BIT  = 2'b11,
		RX_PUSH = 2'b10
	} dtsl_rx_state_type;

endpackage

//--- hw/dtsl_bit_timer.sv
`timescale 1ns/10ps
`include "dtsl_params.svh"

// One delay-loop equivalent: overhead plus segment, counted in clocks
module dtsl_bit_timer #(
	parameter int CW = 24
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       start,
	input  wire logic [7:0] hi_byte,
	input  wire logic [7:0] lo_byte,
	output logic            done
);
	logic [CW-1:0] cnt_ff;
	logic          busy_ff;
	logic [7:0]    lo_red;
	logic [7:0]    hi_red;
	logic [31:0]   total;

	// Each byte is reduced by one; a zero byte wraps to 255 as the loop does
	assign lo_red = lo_byte - 8'h01;
	assign hi_red = hi_byte - 8'h01;

	// Exact loop count, not the linear approximation
	assign total = `DTSL_CLK_PER_MC * (`DTSL_LOOP_OVH + `DTSL_SEG_BASE
		+ `DTSL_STEP_LOW * {24'h0, lo_red}
		+ `DTSL_STEP_HIGH * {24'h0, hi_red});

	// Down counter; done fires total clocks after start
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_ff  <= '0;
			busy_ff <= 1'b0;
		end else if (start) begin
			cnt_ff  <= total[CW-1:0];
			busy_ff <= 1'b1;
		end else if (busy_ff) begin
			cnt_ff  <= cnt_ff - {{(CW-1){1'b0}}, 1'b1};
			if (cnt_ff == {{(CW-1){1'b0}}, 1'b1}) begin
				busy_ff <= 1'b0;
			end
		end
	end

	assign done = busy_ff && (cnt_ff == {{(CW-1){1'b0}}, 1'b1});
endmodule // dtsl_bit_timer

//--- hw/dtsl_skid_buf.sv
`timescale 1ns/10ps

// Two-entry buffer, valid/ready on both sides
module dtsl_skid_buf #(
	parameter int W     = 8,
	parameter int DEPTH = 2
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0]   cnt_ff;
	logic          push;
	logic          pop;

	assign in_ready  = (cnt_ff != DEPTH[AW:0]);
	assign out_valid = (cnt_ff != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_ff[rd_ff];

	// Storage written only on push
	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + AW'(1);
			end
			if (pop) begin
				rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + AW'(1);
			end
			cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule // dtsl_skid_buf

//--- hw/dtsl_serial_link.sv
`timescale 1ns/10ps
`include "dtsl_params.svh"

// Delay-timed serial transmitter and receiver
module dtsl_serial_link #(
	parameter int SLOTS   = `DTSL_SLOTS_LONG,
	parameter int SAMPLES = `DTSL_RX_SAMPLES,
	parameter int BUF_DEPTH = 2
) (
	input  wire logic        MCLK,
	input  wire logic        SRST,
	input  wire logic        SERIAL_INPUT_LINE,
	output logic             SERIAL_OUTPUT_LINE,
	input  wire logic [15:0] FULL_BIT_DELAY,
	input  wire logic [15:0] HALF_BIT_DELAY,
	input  wire logic        TX_SHORT_FRAME,
	input  wire logic        TX_VALID,
	output logic             TX_READY,
	input  wire logic [7:0]  TX_DATA,
	input  wire logic        LINE_WRITE,
	input  wire logic        LINE_WRITE_EN,
	input  wire logic        LINE_WRITE_VAL,
	output logic             RX_VALID,
	input  wire logic        RX_READY,
	output logic [7:0]       RX_DATA,
	output logic             RX_STOP_SAMPLE,
	output logic             IRQ_BLOCK
);
	localparam logic [3:0] SLOTS_L = 4'(SLOTS);
	localparam logic [3:0] SLOTS_S = 4'(`DTSL_SLOTS_SHORT);
	localparam logic [3:0] SMP_N   = 4'(SAMPLES);

	// Input synchroniser
	// The pin is asynchronous, so no logic reads it before two flops
	logic sid_meta_ff;
	logic sid_sync_ff;
	logic sid_prev_ff;

	// Two flops before any logic looks at the pin
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			sid_meta_ff <= 1'b1;
			sid_sync_ff <= 1'b1;
		end else begin
			sid_meta_ff <= SERIAL_INPUT_LINE;
			sid_sync_ff <= sid_meta_ff;
		end
	end

	// Previous synced level for the edge detector
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			sid_prev_ff <= 1'b1;
		end else begin
			sid_prev_ff <= sid_sync_ff;
		end
	end

	// Transmit path
	// One timer restarted per slot; the frame ends after the last slot timer
	dtsl_pkg::dtsl_tx_state_type tx_state_ff;
	dtsl_pkg::dtsl_tx_state_type nxt_tx_state;
	logic [7:0] tx_shift_ff;
	logic [3:0] tx_slots_ff;
	logic       tx_tmr_start;
	logic       tx_tmr_done;
	logic       tx_drive;
	logic       sod_ff;
	logic       nxt_sod;

	// Ready only in idle, so a byte is never taken in mid-frame
	assign TX_READY = (tx_state_ff == dtsl_pkg::TX_IDLE);

	// Shared timer type keeps both directions on the same loop count
	dtsl_bit_timer #(
		.CW(24)
	) u_tx_timer (
		.clk     (MCLK),
		.rst     (SRST),
		.start   (tx_tmr_start),
		.hi_byte (FULL_BIT_DELAY[15:8]),
		.lo_byte (FULL_BIT_DELAY[7:0]),
		.done    (tx_tmr_done)
	);

	// Transmit sequencing
	always_comb begin
		nxt_tx_state = tx_state_ff;
		tx_tmr_start = 1'b0;
		tx_drive     = 1'b0;
		case (tx_state_ff)
			dtsl_pkg::TX_IDLE: begin
				if (TX_VALID) begin
					nxt_tx_state = dtsl_pkg::TX_SLOT;
					tx_tmr_start = 1'b1;
					tx_drive     = 1'b1;
				end
			end
			dtsl_pkg::TX_SLOT: begin
				if (tx_tmr_done) begin
					if (tx_slots_ff == 4'h2) begin
						nxt_tx_state = dtsl_pkg::TX_LAST;
					end
					tx_tmr_start = 1'b1;
					tx_drive     = 1'b1;
				end
			end
			dtsl_pkg::TX_LAST: begin
				if (tx_tmr_done) begin
					nxt_tx_state = dtsl_pkg::TX_IDLE;
				end
			end
			default: begin
				nxt_tx_state = dtsl_pkg::TX_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			tx_state_ff <= dtsl_pkg::TX_IDLE;
		end else begin
			tx_state_ff <= nxt_tx_state;
		end
	end

	// Nine-bit circular shifter: byte register plus output stage
	// The stage itself is sod_ff; only the byte part is kept here
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			tx_shift_ff <= 8'h00;
			tx_slots_ff <= 4'h0;
		end else if (TX_READY && TX_VALID) begin
			tx_shift_ff <= TX_DATA;
			tx_slots_ff <= TX_SHORT_FRAME ? SLOTS_S : SLOTS_L;
		end else if (tx_tmr_done && (tx_state_ff != dtsl_pkg::TX_IDLE)) begin
			// Stage set to one then rotated right; the one reappears nine slots on
			tx_shift_ff <= {1'b1, tx_shift_ff[7:1]};
			tx_slots_ff <= tx_slots_ff - 4'h1;
		end
	end

	// Output level: the slot drive or an explicit enabled write
	always_comb begin
		nxt_sod = sod_ff;
		if (tx_drive) begin
			// Start slot is the cleared output stage, later slots the rotated byte
			nxt_sod = (tx_state_ff == dtsl_pkg::TX_IDLE) ? 1'b0 : tx_shift_ff[0];
		end else if (LINE_WRITE && LINE_WRITE_EN) begin
			nxt_sod = LINE_WRITE_VAL;
		end
	end

	// Pin register; a write without the enable bit leaves it alone
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			sod_ff <= `DTSL_SOD_RST;
		end else begin
			sod_ff <= nxt_sod;
		end
	end

	assign SERIAL_OUTPUT_LINE = sod_ff;

	// Receive path
	// Sampling is timed from the synchronised edge, so both carry the same lag
	dtsl_pkg::dtsl_rx_state_type rx_state_ff;
	dtsl_pkg::dtsl_rx_state_type nxt_rx_state;
	logic [7:0]  rx_shift_ff;
	logic [3:0]  rx_left_ff;
	logic        rx_stop_ff;
	logic        rx_tmr_start;
	logic        rx_tmr_done;
	logic [15:0] rx_delay;
	logic        buf_in_ready;
	logic        rx_push;
	logic        rx_start_edge;

	// Both edge flops reset to the idle level, so reset makes no false start
	assign rx_start_edge = sid_prev_ff && !sid_sync_ff;

	// Half delay for the first wait, full delay afterwards
	assign rx_delay = (rx_state_ff == dtsl_pkg::RX_IDLE) ? HALF_BIT_DELAY : FULL_BIT_DELAY;

	dtsl_bit_timer #(
		.CW(24)
	) u_rx_timer (
		.clk     (MCLK),
		.rst     (SRST),
		.start   (rx_tmr_start),
		.hi_byte (rx_delay[15:8]),
		.lo_byte (rx_delay[7:0]),
		.done    (rx_tmr_done)
	);

	// Receive sequencing; a full buffer holds off the next character
	always_comb begin
		nxt_rx_state = rx_state_ff;
		rx_tmr_start = 1'b0;
		rx_push      = 1'b0;
		case (rx_state_ff)
			dtsl_pkg::RX_IDLE: begin
				if (rx_start_edge && buf_in_ready) begin
					nxt_rx_state = dtsl_pkg::RX_HALF;
					rx_tmr_start = 1'b1;
				end
			end
			dtsl_pkg::RX_HALF: begin
				if (rx_tmr_done) begin
					nxt_rx_state = dtsl_pkg::RX_BIT;
					rx_tmr_start = 1'b1;
				end
			end
			dtsl_pkg::RX_BIT: begin
				if (rx_tmr_done) begin
					if (rx_left_ff == 4'h1) begin
						nxt_rx_state = dtsl_pkg::RX_PUSH;
					end else begin
						rx_tmr_start = 1'b1;
					end
				end
			end
			dtsl_pkg::RX_PUSH: begin
				// Holds here until the buffer takes the byte
				rx_push = 1'b1;
				if (buf_in_ready) begin
					nxt_rx_state = dtsl_pkg::RX_IDLE;
				end
			end
			default: begin
				nxt_rx_state = dtsl_pkg::RX_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			rx_state_ff <= dtsl_pkg::RX_IDLE;
		end else begin
			rx_state_ff <= nxt_rx_state;
		end
	end

	// Sampling: data enters at the top, the ninth sample is the stop bit
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			rx_shift_ff <= 8'h00;
			rx_left_ff  <= 4'h0;
			rx_stop_ff  <= 1'b1;
		end else if (rx_state_ff == dtsl_pkg::RX_IDLE) begin
			// Reload the sample count while waiting for a start edge
			rx_left_ff <= SMP_N;
		end else if ((rx_state_ff == dtsl_pkg::RX_BIT) && rx_tmr_done) begin
			rx_left_ff <= rx_left_ff - 4'h1;
			if (rx_left_ff == 4'h1) begin
				rx_stop_ff <= sid_sync_ff;
			end else begin
				rx_shift_ff <= {sid_sync_ff, rx_shift_ff[7:1]};
			end
		end
	end

	// Stop level is only reported; a zero there is not flagged as an error
	assign RX_STOP_SAMPLE = rx_stop_ff;

	// Holding buffer so a slow consumer loses no byte already taken
	// A character that meets a full buffer is dropped at its start edge
	dtsl_skid_buf #(
		.W     (8),
		.DEPTH (BUF_DEPTH)
	) u_rx_buf (
		.clk       (MCLK),
		.rst       (SRST),
		.in_valid  (rx_push),
		.in_ready  (buf_in_ready),
		.in_data   (rx_shift_ff),
		.out_valid (RX_VALID),
		.out_ready (RX_READY),
		.out_data  (RX_DATA)
	);

	// Activity flag
	// Covers both directions, since either one depends on undisturbed timing
	logic irq_block_ff;

	// Registered so the processor sees a clean level during frames
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			irq_block_ff <= 1'b0;
		end else begin
			irq_block_ff <= (nxt_tx_state != dtsl_pkg::TX_IDLE)
				|| (nxt_rx_state != dtsl_pkg::RX_IDLE);
		end
	end

	// Built from next state, so it rises with the accepting edge itself
	assign IRQ_BLOCK = irq_block_ff;
endmodule // dtsl_serial_link

//--- verification/dtsl_link_asserts.sv
`timescale 1ns/10ps

// Timing relations of the link, derived from the live full-bit delay
module dtsl_link_asserts #(
	parameter int SLOTS = 11
) (
	input wire logic        MCLK,
	input wire logic        SRST,
	input wire logic        SERIAL_INPUT_LINE,
	input wire logic        SERIAL_OUTPUT_LINE,
	input wire logic [15:0] FULL_BIT_DELAY,
	input wire logic        TX_SHORT_FRAME,
	input wire logic        TX_VALID,
	input wire logic        TX_READY,
	input wire logic        LINE_WRITE,
	input wire logic        LINE_WRITE_EN,
	input wire logic        LINE_WRITE_VAL,
	input wire logic        RX_VALID,
	input wire logic        RX_READY,
	input wire logic [7:0]  RX_DATA,
	input wire logic        IRQ_BLOCK
);
	logic [7:0] lo_m;
	logic [7:0] hi_m;
	int         per;
	int         run_ff;
	int         busy_ff;
	logic       prev_ff;
	logic       short_ff;

	// Reduced bytes wrap like eight-bit loop counters
	assign lo_m = FULL_BIT_DELAY[7:0] - 8'h01;
	assign hi_m = FULL_BIT_DELAY[15:8] - 8'h01;
	assign per  = 2 * (83 + 14 * int'(lo_m) + 3595 * int'(hi_m));

	// Age of the present output level
	always_ff @(posedge MCLK) begin
		prev_ff <= SERIAL_OUTPUT_LINE;
		run_ff  <= (SERIAL_OUTPUT_LINE != prev_ff) ? 1 : run_ff + 1;
	end

	// Busy span of the transmitter; frame length is fixed at accept
	always_ff @(posedge MCLK) begin
		busy_ff <= TX_READY ? 0 : busy_ff + 1;
		if (TX_VALID && TX_READY) begin
			short_ff <= TX_SHORT_FRAME;
		end
	end

	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (SRST);

	property p_rst_low;
		$fell(SRST) |-> !SERIAL_OUTPUT_LINE;
	endproperty
	a_rst_low: assert property (p_rst_low) else $error("output high after reset");

	property p_tx_start;
		TX_VALID && TX_READY |=> !TX_READY ##[0:1] !SERIAL_OUTPUT_LINE;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("no start slot");

	// Equal bits merge, so a run spans whole slots; the accepting edge starts a run
	property p_slot_len;
		$changed(SERIAL_OUTPUT_LINE) && !TX_READY && !$past(TX_READY) |-> run_ff % per == 0;
	endproperty
	a_slot_len: assert property (p_slot_len) else $error("slot length off");

	property p_tx_len;
		$rose(TX_READY) |-> busy_ff - (short_ff ? SLOTS - 1 : SLOTS) * per inside {0, 1};
	endproperty
	a_tx_len: assert property (p_tx_len) else $error("frame length off");

	property p_tail_ones;
		!TX_READY && busy_ff > 9 * per + 1 |-> SERIAL_OUTPUT_LINE;
	endproperty
	a_tail_ones: assert property (p_tail_ones) else $error("tail slot not one");

	property p_line_set;
		LINE_WRITE && LINE_WRITE_EN && TX_READY && !TX_VALID
			|=> SERIAL_OUTPUT_LINE == $past(LINE_WRITE_VAL);
	endproperty
	a_line_set: assert property (p_line_set) else $error("write not applied");

	property p_line_keep;
		LINE_WRITE && !LINE_WRITE_EN && TX_READY && !TX_VALID |=> $stable(SERIAL_OUTPUT_LINE);
	endproperty
	a_line_keep: assert property (p_line_keep) else $error("disabled write moved line");

	property p_rx_start;
		$fell(SERIAL_INPUT_LINE) && TX_READY && !IRQ_BLOCK && !RX_VALID |-> ##[2:6] IRQ_BLOCK;
	endproperty
	a_rx_start: assert property (p_rx_start) else $error("start edge missed");

	property p_rx_hold;
		RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_DATA);
	endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("byte lost in stall");

	c_tx_short: cover property (TX_VALID && TX_READY && TX_SHORT_FRAME);
	c_rx_stall: cover property (RX_VALID && !RX_READY ##1 RX_VALID);
	c_write_off: cover property (LINE_WRITE && !LINE_WRITE_EN);
endmodule // dtsl_link_asserts

//--- verification/dtsl_term_model.sv
`timescale 1ns/10ps

// Far-end terminal: line idles at mark, bits last PER clocks
module dtsl_term_model #(
	parameter int PER = 334
) (
	input  wire logic clk,
	input  wire logic from_dut,
	output logic      to_dut
);
	int per_clk;

	// The clock never drifts here; a new rate comes with a new per_clk
	initial begin
		to_dut  = 1'b1;
		per_clk = PER;
	end

	// A zero stop level makes a framing fault on purpose
	task automatic send_byte(input logic [7:0] d, input logic stop);
		logic [9:0] f;
		f = {stop, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(negedge clk);
			to_dut = (i < 10) ? f[i] : 1'b1;
			repeat (per_clk - 1) @(negedge clk);
		end
	endtask

	// Samples mid-bit, timed from the falling start edge
	task automatic recv_byte(output logic [7:0] d, output logic stop);
		int n;
		n = 0;
		while (from_dut !== 1'b0 && n < 20000) begin
			@(negedge clk);
			n++;
		end
		repeat (per_clk / 2) @(negedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (per_clk) @(negedge clk);
			d[i] = from_dut;
		end
		repeat (per_clk) @(negedge clk);
		stop = from_dut;
	endtask
endmodule // dtsl_term_model

//--- verification/delay_timed_serial_link_test.sv
`timescale 1ns/10ps

// Direct writes, transmit frames, receive with faults and stalls
module delay_timed_serial_link_test;
	// Full delay 16'h0107 and half delay 16'h0101 in clocks
	localparam int PER = 2 * (83 + 14 * 6);
	// One delay step up, full delay 16'h0108
	localparam int PER2 = 2 * (83 + 14 * 7);
	logic       mclk;
	logic       srst;
	logic       sin;
	logic       sout;
	logic       tx_short;
	logic       tx_valid;
	logic       tx_ready;
	logic [7:0] tx_data;
	logic       lw;
	logic       lw_en;
	logic       lw_val;
	logic       rx_valid;
	logic       rx_ready;
	logic [7:0] rx_data;
	logic       rx_stop;
	logic       irq;
	logic [15:0] full_dly;
	logic [15:0] half_dly;
	int         num_errors;
	int         n_compared;

	dtsl_serial_link DUT (
		.MCLK(mclk),
		.SRST(srst),
		.SERIAL_INPUT_LINE(sin),
		.SERIAL_OUTPUT_LINE(sout),
		.FULL_BIT_DELAY(full_dly),
		.HALF_BIT_DELAY(half_dly),
		.TX_SHORT_FRAME(tx_short),
		.TX_VALID(tx_valid),
		.TX_READY(tx_ready),
		.TX_DATA(tx_data),
		.LINE_WRITE(lw),
		.LINE_WRITE_EN(lw_en),
		.LINE_WRITE_VAL(lw_val),
		.RX_VALID(rx_valid),
		.RX_READY(rx_ready),
		.RX_DATA(rx_data),
		.RX_STOP_SAMPLE(rx_stop),
		.IRQ_BLOCK(irq)
	);

	dtsl_term_model #(.PER(PER)) u_term (
		.clk(mclk),
		.from_dut(sout),
		.to_dut(sin)
	);

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic check_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic give_verdict;
		$display("errors=%0d compared=%0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic line_wr(input logic en, input logic val);
		@(negedge mclk);
		lw     = 1'b1;
		lw_en  = en;
		lw_val = val;
		@(negedge mclk);
		lw = 1'b0;
	endtask

	// Waits for the transmitter, hands over one byte
	task automatic send_tx(input logic [7:0] d, input logic short);
		int n;
		n = 0;
		while (tx_ready !== 1'b1 && n < 10000) begin
			@(negedge mclk);
			n++;
		end
		tx_valid = 1'b1;
		tx_data  = d;
		tx_short = short;
		@(negedge mclk);
		tx_valid = 1'b0;
		check_bit(tx_ready, 1'b0);
		@(negedge mclk);
		check_bit(irq, 1'b1);
	endtask

	// First wait has one extra cycle so a held byte is never taken twice
	task automatic read_rx(input logic [7:0] exp, input logic stop);
		int n;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (rx_valid !== 1'b1 && n < 6000);
		check_bit(rx_valid, 1'b1);
		check_byte(rx_data, exp);
		check_bit(rx_stop, stop);
		rx_ready = 1'b1;
		@(negedge mclk);
		rx_ready = 1'b0;
	endtask

	task automatic t_reset;
		repeat (10) @(negedge mclk);
		check_bit(sout, 1'b0);
		srst = 1'b0;
		@(negedge mclk);
		check_bit(sout, 1'b0);
		check_bit(tx_ready, 1'b1);
		check_bit(rx_valid, 1'b0);
	endtask

	task automatic t_line_write;
		line_wr(1'b1, 1'b1);
		check_bit(sout, 1'b1);
		line_wr(1'b0, 1'b0);
		check_bit(sout, 1'b1);
		line_wr(1'b1, 1'b0);
		check_bit(sout, 1'b0);
		line_wr(1'b1, 1'b1);
	endtask

	// Long frame then short frame, second handed over as soon as ready
	task automatic t_tx;
		logic [7:0] d0;
		logic [7:0] d1;
		logic       s0;
		logic       s1;
		fork
			begin
				send_tx(8'hA5, 1'b0);
				send_tx(8'h3C, 1'b1);
			end
			begin
				u_term.recv_byte(d0, s0);
				u_term.recv_byte(d1, s1);
			end
		join
		check_byte(d0, 8'hA5);
		check_bit(s0, 1'b1);
		check_byte(d1, 8'h3C);
		check_bit(s1, 1'b1);
		repeat (PER) @(negedge mclk);
		check_bit(tx_ready, 1'b1);
		check_bit(sout, 1'b1);
	endtask

	// Rate character, then an asymmetric byte with a broken stop bit
	task automatic t_rx;
		fork
			u_term.send_byte(8'h20, 1'b1);
			read_rx(8'h20, 1'b1);
		join
		fork
			u_term.send_byte(8'hC1, 1'b0);
			read_rx(8'hC1, 1'b0);
		join
	endtask

	// Consumer stalls over three frames; the third meets a full buffer
	task automatic t_stall;
		u_term.send_byte(8'h11, 1'b1);
		u_term.send_byte(8'h22, 1'b1);
		u_term.send_byte(8'h33, 1'b1);
		check_bit(rx_valid, 1'b1);
		read_rx(8'h11, 1'b1);
		read_rx(8'h22, 1'b1);
		@(negedge mclk);
		check_bit(rx_valid, 1'b0);
	endtask

	// Next delay step: both directions follow the new period
	task automatic t_rate;
		logic [7:0] d;
		logic       s;
		full_dly       = 16'h0108;
		u_term.per_clk = PER2;
		fork
			send_tx(8'h5A, 1'b0);
			u_term.recv_byte(d, s);
		join
		check_byte(d, 8'h5A);
		check_bit(s, 1'b1);
		fork
			u_term.send_byte(8'h96, 1'b1);
			read_rx(8'h96, 1'b1);
		join
	endtask

	initial begin
		num_errors = 0;
		n_compared = 0;
		srst       = 1'b1;
		full_dly   = 16'h0107;
		half_dly   = 16'h0101;
		tx_short   = 1'b0;
		tx_valid   = 1'b0;
		tx_data    = 8'h00;
		lw         = 1'b0;
		lw_en      = 1'b0;
		lw_val     = 1'b0;
		rx_ready   = 1'b0;
		t_reset();
		t_line_write();
		t_tx();
		t_rx();
		t_stall();
		t_rate();
		give_verdict();
	end

	// Nine frames of at most 11 slots take about 35000 clocks
	initial begin
		repeat (80000) @(posedge mclk);
		num_errors++;
		give_verdict();
	end
endmodule // delay_timed_serial_link_test

bind dtsl_serial_link dtsl_link_asserts #(
	.SLOTS(SLOTS)
) u_chk (
	.MCLK(MCLK),
	.SRST(SRST),
	.SERIAL_INPUT_LINE(SERIAL_INPUT_LINE),
	.SERIAL_OUTPUT_LINE(SERIAL_OUTPUT_LINE),
	.FULL_BIT_DELAY(FULL_BIT_DELAY),
	.TX_SHORT_FRAME(TX_SHORT_FRAME),
	.TX_VALID(TX_VALID),
	.TX_READY(TX_READY),
	.LINE_WRITE(LINE_WRITE),
	.LINE_WRITE_EN(LINE_WRITE_EN),
	.LINE_WRITE_VAL(LINE_WRITE_VAL),
	.RX_VALID(RX_VALID),
	.RX_READY(RX_READY),
	.RX_DATA(RX_DATA),
	.IRQ_BLOCK(IRQ_BLOCK)
);
